// file: shared/irq_front_defines.vh
// Constants for the interrupt pin front end.
`ifndef IRQ_FRONT_DEFINES_VH
`define IRQ_FRONT_DEFINES_VH
`define REG_STATUS       12'h000
`define REG_ENABLE       12'h004
`define REG_CLEAR        12'h008
`define REG_POLARITY     12'h00C
`define REG_SERVICE      12'h010
`define REG_ACK_INFO     12'h014
`define POLARITY_RESET   4'h0
`define ENABLE_RESET     5'h00
`define STATUS_NMI_BIT   4
`define IRQ_NUM_NMI      4'h1
`define IRQ_NUM_EXT0     4'h4
`define ACK_CYCLES       2'h2
`define SYNC_WARMUP      2'h3
`endif

// file: core/irq_pin_front_end.v
// Interrupt pin front end: edge detection, pending status, acknowledge and number outputs.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_front_defines.vh"
// Notes on behaviour
// (RULE1) Nonmaskable input triggers on rising edge only.
// (RULE2) External inputs are edge sensitive, not level.
// (RULE3) Per-pin polarity bit chooses active edge.
// (RULE4) Acknowledge pulses for every serviced interrupt reported while no acknowledge is high.
// (RULE5) Number output valid throughout the acknowledge.
// (RULE6) Number follows service vector ordering.
// (RULE7) Two-flop sync, compare samples, one-cycle pulse.
module irq_pin_front_end (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        nmi_in,
   input  wire        ext_irq_in_0,
   input  wire        ext_irq_in_1,
   input  wire        ext_irq_in_2,
   input  wire        ext_irq_in_3,
   output wire        irq_out,
   output reg         irq_ack_out,
   output reg  [3:0]  irq_number_out
);

   // ********************************************************
   // Synchronisers and edge detection
   // ********************************************************
   // Bit order of every five-bit vector below: [3:0] are the external pins
   // 0 to 3 and [4] is the nonmaskable pin.
   wire [4:0] raw_in;
   reg  [4:0] sync1_ff;
   reg  [4:0] sync2_ff;
   reg  [4:0] prev_ff;
   reg  [1:0] warm_ff;
   reg  [1:0] nxt_warm;
   reg  [3:0] ext_irq_polarity_bits_ff;
   wire       warm_done;
   wire [4:0] rise;
   wire [4:0] fall;
   wire [4:0] edge_raw;
   wire [4:0] edge_hit;

   assign raw_in = {nmi_in, ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0};
   assign rise   = sync2_ff & ~prev_ff;
   assign fall   = ~sync2_ff & prev_ff;

   // The pins are asynchronous to pclk, so sync1_ff may go metastable.
   // Only sync2_ff reads it; every piece of logic looks at sync2_ff or later.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         prev_ff  <= 5'h00;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff; // see (RULE7)
         prev_ff  <= sync2_ff;
      end
   end

   // Reset clears the chain to zero, yet a pin may idle high.
   // Until the chain holds real pin levels, a difference between sync2_ff
   // and prev_ff is left over from reset and not an edge, so it is masked.
   // Limitation: a pin that truly changes in the first cycles is not seen.
   always @* begin
      nxt_warm = warm_ff;
      if (warm_ff != `SYNC_WARMUP)
         nxt_warm = warm_ff + 2'h1;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warm_ff <= 2'h0;
      end else begin
         warm_ff <= nxt_warm;
      end
   end

   assign warm_done = (warm_ff == `SYNC_WARMUP);

   // Polarity bit low selects the rising edge, high selects the falling edge.
   // A held level gives no edge, so a stuck pin raises its status only once.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ext_edge
         assign edge_raw[g] = ext_irq_polarity_bits_ff[g] ? fall[g] : rise[g]; // see (RULE2) (RULE3)
      end
   endgenerate

   // The nonmaskable pin has no polarity choice: it always wants a rise.
   assign edge_raw[4] = rise[4]; // see (RULE1)

   // Each detected edge is a pulse of exactly one cycle.
   assign edge_hit = warm_done ? edge_raw : 5'h00; // see (RULE7)

   // ********************************************************
   // Register bus
   // ********************************************************
   // One decoder serves every register write compare, so that no two writes can
   // disagree about which offset is meant.
   function addr_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   wire        wr_en;
   wire        rd_setup;
   wire        clr_wr;
   wire        enable_wr;
   wire        polarity_wr;
   wire        svc_wr;
   wire [4:0]  clr_bits;
   reg  [4:0]  status_ff;
   reg  [4:0]  enable_ff;
   reg  [4:0]  nxt_status;
   reg  [31:0] rd_mux;
   reg  [1:0]  ack_cnt_ff;

   assign wr_en       = psel & penable & pwrite;
   assign rd_setup    = psel & ~penable & ~pwrite;
   assign clr_wr      = wr_en & addr_hit(paddr, `REG_CLEAR);
   assign enable_wr   = wr_en & addr_hit(paddr, `REG_ENABLE);
   assign polarity_wr = wr_en & addr_hit(paddr, `REG_POLARITY);
   assign svc_wr      = wr_en & addr_hit(paddr, `REG_SERVICE);
   assign clr_bits    = clr_wr ? pwdata[4:0] : 5'h00;

   // Every access completes in its first access cycle; nothing is refused
   // with an error, unmapped offsets simply read zero.
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Level output: high while any enabled status bit is set.
   assign irq_out = |(status_ff & enable_ff);

   // Set wins over clear so an edge landing with a clear write is kept.
   always @* begin
      nxt_status = (status_ff & ~clr_bits) | edge_hit;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff                <= 5'h00;
         enable_ff                <= `ENABLE_RESET;
         ext_irq_polarity_bits_ff <= `POLARITY_RESET;
      end else begin
         status_ff <= nxt_status;
         if (enable_wr)
            enable_ff <= pwdata[4:0];
         if (polarity_wr)
            ext_irq_polarity_bits_ff <= pwdata[3:0];
      end
   end

   always @* begin
      case (paddr)
         `REG_STATUS:   rd_mux = {27'h0, status_ff};
         `REG_ENABLE:   rd_mux = {27'h0, enable_ff};
         `REG_POLARITY: rd_mux = {28'h0, ext_irq_polarity_bits_ff};
         `REG_ACK_INFO: rd_mux = {27'h0, irq_ack_out, irq_number_out};
         default:       rd_mux = 32'h0;
      endcase
   end

   // Read data is captured in the setup cycle, so it comes from a flip-flop
   // and still stands in the access cycle with no wait state. The trade-off:
   // a status bit set during the access cycle shows on the next read.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // ********************************************************
   // Acknowledge and number
   // ********************************************************
   // The core reports a serviced interrupt by writing its vector number to the
   // service register; any source, internal or external, may be reported.
   // A report that arrives while the strobe is still high is dropped, so the
   // number can never change under an acknowledge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_cnt_ff     <= 2'h0;
         irq_ack_out    <= 1'b0;
         irq_number_out <= 4'h0;
      end else if (svc_wr && ack_cnt_ff == 2'h0) begin
         ack_cnt_ff     <= `ACK_CYCLES;
         irq_ack_out    <= 1'b1; // see (RULE4)
         irq_number_out <= pwdata[3:0]; // see (RULE5) (RULE6)
      end else if (ack_cnt_ff != 2'h0) begin
         ack_cnt_ff  <= ack_cnt_ff - 2'h1;
         irq_ack_out <= (ack_cnt_ff != 2'h1);
      end
   end

endmodule // irq_pin_front_end

// file: verification/irq_front_assertions.sv
// Checker for the interrupt pin front end.
`timescale 1ns/1ps
`include "irq_front_defines.vh"
module irq_front_assertions (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        irq_ack_out,
   input wire [3:0]  irq_number_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire svc_seen;
   assign svc_seen = psel && penable && pwrite && paddr == `REG_SERVICE;
   property p_ack; $rose(irq_ack_out) |=> irq_ack_out ##1 !irq_ack_out; endproperty
   a_ack: assert property (p_ack) else $error("ack width");
   property p_num; $rose(irq_ack_out) |=> $stable(irq_number_out)[*2]; endproperty
   a_num: assert property (p_num) else $error("number moved");
   property p_svc; svc_seen && !irq_ack_out
      |=> $rose(irq_ack_out) && irq_number_out == $past(pwdata[3:0]); endproperty
   a_svc: assert property (p_svc) else $error("service");
   property p_ack_src; $rose(irq_ack_out) |-> $past(svc_seen); endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without service");
   property p_ack_max; irq_ack_out ##1 irq_ack_out |=> !irq_ack_out; endproperty
   a_ack_max: assert property (p_ack_max) else $error("ack too long");
   property p_num_hold; !$past(svc_seen) |-> $stable(irq_number_out); endproperty
   a_num_hold: assert property (p_num_hold) else $error("number not held");
endmodule // irq_front_assertions
bind irq_pin_front_end irq_front_assertions chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .irq_ack_out, .irq_number_out);

// file: verification/irq_source_model.sv
// Model of the board interrupt sources.
`timescale 1ns/1ps
module irq_source_model (
   input wire       pclk,
   output reg       nmi_in,
   output reg [3:0] ext_irq
);
   initial {nmi_in, ext_irq} = 5'h00;
   task drive(input [4:0] v); @(posedge pclk); {nmi_in, ext_irq} <= v; endtask
endmodule // irq_source_model

// file: verification/tb_top.sv
// Self-checking bench for the interrupt pin front end.
`timescale 1ns/1ps
`include "irq_front_defines.vh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, v); end end
module tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, irq_out, irq_ack_out, nmi_in;
   logic [3:0]  irq_number_out, ext;
   int          errors = 0, comparisons = 0, cyc = 0;
   always #2 pclk = ~pclk;
   irq_source_model src (.pclk, .nmi_in, .ext_irq(ext));
   irq_pin_front_end dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr(), .nmi_in, .ext_irq_in_0(ext[0]), .ext_irq_in_1(ext[1]),
      .ext_irq_in_2(ext[2]), .ext_irq_in_3(ext[3]), .irq_out, .irq_ack_out, .irq_number_out);
   task final_report;
      if (errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task rc(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(0, a, 0); `CHK(n, e, rd)
   endtask
   // Pins need three edges to reach status through the synchroniser.
   task pin(input logic [4:0] v); src.drive(v); repeat (3) @(posedge pclk); endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin errors++; final_report; end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rc(`REG_ENABLE, 0, "enable"); rc(`REG_POLARITY, 0, "polarity");
      apb(1, `REG_ENABLE, 32'h1F);
      pin(5'h01); rc(`REG_STATUS, 32'h01, "status");
      `CHK("irq", 1'b1, irq_out)
      apb(1, `REG_CLEAR, 32'h1F); rc(`REG_STATUS, 0, "status");
      `CHK("irq", 1'b0, irq_out)
      apb(1, `REG_POLARITY, 32'h2);
      pin(5'h03); rc(`REG_STATUS, 0, "status");
      pin(5'h01); rc(`REG_STATUS, 32'h02, "status");
      apb(1, `REG_CLEAR, 32'h1F);
      pin(5'h11); rc(`REG_STATUS, 32'h10, "status");
      apb(1, `REG_CLEAR, 32'h1F);
      pin(5'h01); rc(`REG_STATUS, 0, "status");
      apb(1, `REG_SERVICE, `IRQ_NUM_NMI); `CHK("num", `IRQ_NUM_NMI, irq_number_out)
      `CHK("ack", 1'b1, irq_ack_out)
      repeat (2) @(posedge pclk);
      apb(1, `REG_SERVICE, `IRQ_NUM_EXT0); `CHK("num", `IRQ_NUM_EXT0, irq_number_out)
      // The read's setup edge falls in the second acknowledge cycle.
      rc(`REG_ACK_INFO, {27'h0, 1'b1, `IRQ_NUM_EXT0}, "ack_info");
      rc(12'h020, 0, "unmapped");
      final_report;
   end
endmodule // tb_top
